// ---- common/cmi_pkg.sv ----
/*
 Shared constants and types for the cell monitor two-wire control port.
 Assumes a 100 MHz pclk at both ends.
*/
package cmi_pkg;
	// --------------------------------------------------------------
	// Addressing and register map
	// --------------------------------------------------------------
	localparam logic [6:0] SLV_ADDR = 7'h5c;
	localparam logic DIR_WR = 1'b0;
	localparam logic DIR_RD = 1'b1;
	localparam logic [7:0] REG_SMC = 8'h00;
	localparam logic [7:0] REG_CBC = 8'h01;
	localparam logic [7:0] SMC_RST = 8'h00;
	localparam logic [7:0] CBC_RST = 8'h00;
	localparam int SMC_SLEEP_BIT = 7;
	localparam int SMC_WAKE_BIT = 6;
	localparam int SMC_EN_BIT = 5;
	localparam int SMC_RSV_LSB = 3;
	localparam int RSV_W = 2;
	localparam int SMC_SEL_LSB = 0;
	localparam int SEL_W = 3;
	// --------------------------------------------------------------
	// Framing
	// --------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [1:0] BY_ADDR = 2'h0;
	localparam logic [1:0] BY_REG = 2'h1;
	localparam logic [1:0] BY_DATA = 2'h2;
	localparam logic [1:0] BY_MORE = 2'h3;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int WAKE_FILT_US = 10;
	localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
	localparam int BUS_TIMEOUT_PERIOD_SHORT_MS = 32;
	localparam int BUS_TIMEOUT_PERIOD_LONG_MS = 64;
	// --------------------------------------------------------------
	// Controller registers and transfer steps
	// --------------------------------------------------------------
	localparam logic [11:0] HOST_CMD_OFS = 12'h000;
	localparam logic [11:0] HOST_STAT_OFS = 12'h004;
	localparam int CMD_REG_LSB = 0;
	localparam int CMD_DAT_LSB = 8;
	localparam int CMD_RD_BIT = 16;
	localparam logic [2:0] STEP_AW = 3'h1;
	localparam logic [2:0] STEP_REG = 3'h2;
	localparam logic [2:0] STEP_DAT = 3'h3;
	localparam logic [2:0] STEP_AR = 3'h4;
	localparam logic [2:0] STEP_RD = 3'h5;
	typedef enum logic [4:0] {
		SL_IDLE = 5'h01,
		SL_RX = 5'h02,
		SL_ACK = 5'h04,
		SL_TX = 5'h08,
		SL_MACK = 5'h10
	} cmi_sl_st_t;
	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_START = 4'h2,
		MS_BIT = 4'h4,
		MS_STOP = 4'h8
	} cmi_ms_st_t;
endpackage

// ---- common/cmi_bus_if.sv ----
/*
 Two-wire bus carrier joining controller and monitor port.
 Resolves the wired-AND of all open-drain enables; pull-ups are implied.
*/
`timescale 1ns/1ns
interface cmi_bus_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic scl_s_o;
	logic scl_s_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// Released line reads high
	assign scl = ~(scl_m_oe | scl_s_oe);
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport master (input scl, input sda, output scl_m_o, output scl_m_oe,
		output sda_m_o, output sda_m_oe);
	modport slave (input scl, input sda, output scl_s_o, output scl_s_oe,
		output sda_s_o, output sda_s_oe);
endinterface

// ---- hw/cmi_slave.sv ----
/*
 Monitor end: two-wire slave with two 8-bit control registers,
 wake filter and bus lockup time-out.
 Assumes the bus pins and the wake and fuse levels are asynchronous to pclk.
*/
`timescale 1ns/1ns
module cmi_slave #(
	parameter int BUS_TIMEOUT_PERIOD_SHORT_CYC = cmi_pkg::BUS_TIMEOUT_PERIOD_SHORT_MS * cmi_pkg::CYC_PER_MS,
	parameter int BUS_TIMEOUT_PERIOD_LONG_CYC = cmi_pkg::BUS_TIMEOUT_PERIOD_LONG_MS * cmi_pkg::CYC_PER_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	cmi_bus_if.slave bus,
	input wire logic high_voltage_wake_pin,
	input wire logic bus_timeout_period_long_sel,
	output logic sleep_request,
	output logic monitor_enable,
	output logic [cmi_pkg::SEL_W-1:0] cell_select,
	output logic [7:0] cell_tap_select,
	output logic [7:0] balance_switch_enable
);
	import cmi_pkg::*;

	localparam int TW = $clog2(BUS_TIMEOUT_PERIOD_LONG_CYC + 1);
	localparam int WK_W = $clog2(WAKE_FILT_CYC + 1);
	localparam logic [WK_W-1:0] WK_LIM = WK_W'(WAKE_FILT_CYC);

	logic [1:0] scl_s, sda_s, wk_s, fz_s;
	logic scl_p, sda_p;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic busy_q, to_exp;
	logic [TW-1:0] to_q, bus_timeout_period_lim;
	cmi_sl_st_t st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_q, rd_data;
	logic [1:0] byte_q;
	logic rw_q, mack_q, sda_oe_q, zero_q;
	logic rx_done, wr_stb;
	logic sleep_q, wwake_q, en_q, pin_flag_q, wake_eff;
	logic [RSV_W-1:0] rsv_q;
	logic [SEL_W-1:0] sel_q;
	logic [7:0] bal_q, tap_q;
	logic [WK_W-1:0] wk_cnt_q;

	// ----------------------------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			wk_s <= 2'h0;
			fz_s <= 2'h0;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], bus.scl};
			sda_s <= {sda_s[0], bus.sda};
			wk_s <= {wk_s[0], high_voltage_wake_pin};
			fz_s <= {fz_s[0], bus_timeout_period_long_sel};
			scl_p <= scl_s[1];
			sda_p <= sda_s[1];
		end
	end

	assign scl_rise = scl_s[1] & ~scl_p;
	assign scl_fall = ~scl_s[1] & scl_p;
	assign start_ev = scl_s[1] & scl_p & sda_p & ~sda_s[1];
	assign stop_ev = scl_s[1] & scl_p & ~sda_p & sda_s[1];

	// ----------------------------------------------------------
	// Bus busy and lockup time-out
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else if (start_ev) begin
			busy_q <= 1'b1;
		end else if (stop_ev || to_exp) begin
			busy_q <= 1'b0;
		end
	end

	assign bus_timeout_period_lim = fz_s[1] ? TW'(BUS_TIMEOUT_PERIOD_LONG_CYC) : TW'(BUS_TIMEOUT_PERIOD_SHORT_CYC);
	assign to_exp = busy_q && (to_q == bus_timeout_period_lim - TW'(1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_q <= '0;
		end else if (start_ev || scl_fall || !busy_q) begin
			to_q <= '0;
		end else begin
			to_q <= to_q + TW'(1);
		end
	end

	// ----------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------
	assign rx_done = (st_q == SL_RX) && scl_fall && (bit_q == BYTE_BITS);
	assign wr_stb = rx_done && (byte_q == BY_DATA);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= SL_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			byte_q <= BY_ADDR;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start_ev) begin
			st_q <= SL_RX;
			bit_q <= 4'h0;
			byte_q <= BY_ADDR;
			sda_oe_q <= 1'b0;
		end else if (stop_ev || to_exp) begin
			st_q <= SL_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (st_q)
				SL_IDLE: begin
				end
				SL_RX: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s[1]};
						bit_q <= bit_q + 4'h1;
					end else if (rx_done) begin
						if (byte_q == BY_ADDR && sh_q[7:1] != SLV_ADDR) begin
							st_q <= SL_IDLE;
						end else begin
							st_q <= SL_ACK;
							sda_oe_q <= 1'b1;
							if (byte_q == BY_ADDR) begin
								rw_q <= sh_q[0];
							end
							if (byte_q != BY_MORE) begin
								byte_q <= byte_q + 2'h1;
							end
						end
					end
				end
				SL_ACK: begin
					if (scl_fall) begin
						bit_q <= 4'h0;
						if (rw_q == DIR_RD && byte_q == BY_REG) begin
							st_q <= SL_TX;
							sh_q <= rd_data;
							sda_oe_q <= ~rd_data[7];
						end else begin
							st_q <= SL_RX;
							sda_oe_q <= 1'b0;
						end
					end
				end
				SL_TX: begin
					if (scl_fall) begin
						if (bit_q == LAST_BIT) begin
							st_q <= SL_MACK;
							sda_oe_q <= 1'b0;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				SL_MACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s[1];
					end else if (scl_fall) begin
						if (mack_q) begin
							st_q <= SL_TX;
							sh_q <= rd_data;
							sda_oe_q <= ~rd_data[7];
							bit_q <= 4'h0;
						end else begin
							st_q <= SL_IDLE;
						end
					end
				end
				default: begin
					st_q <= SL_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Pointer survives a repeated start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= 8'h00;
		end else if (rx_done && byte_q == BY_REG) begin
			ptr_q <= sh_q;
		end
	end

	// ----------------------------------------------------------
	// Wake pin filter
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wk_cnt_q <= '0;
			pin_flag_q <= 1'b0;
		end else if (!wk_s[1]) begin
			wk_cnt_q <= '0;
			pin_flag_q <= 1'b0;
		end else if (wk_cnt_q == WK_LIM) begin
			pin_flag_q <= 1'b1;
		end else begin
			wk_cnt_q <= wk_cnt_q + WK_W'(1);
		end
	end

	assign wake_eff = pin_flag_q | wwake_q;

	// ----------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_q <= SMC_RST[SMC_SLEEP_BIT];
		end else if (wake_eff) begin
			sleep_q <= 1'b0;
		end else if (wr_stb && ptr_q == REG_SMC) begin
			sleep_q <= sh_q[SMC_SLEEP_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wwake_q <= SMC_RST[SMC_WAKE_BIT];
			en_q <= SMC_RST[SMC_EN_BIT];
			rsv_q <= SMC_RST[SMC_RSV_LSB +: RSV_W];
			sel_q <= SMC_RST[SMC_SEL_LSB +: SEL_W];
			bal_q <= CBC_RST;
		end else if (wr_stb && ptr_q == REG_SMC) begin
			wwake_q <= sh_q[SMC_WAKE_BIT];
			en_q <= sh_q[SMC_EN_BIT];
			rsv_q <= sh_q[SMC_RSV_LSB +: RSV_W];
			sel_q <= sh_q[SMC_SEL_LSB +: SEL_W];
		end else if (wr_stb && ptr_q == REG_CBC) begin
			bal_q <= sh_q;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		if (ptr_q == REG_SMC) begin
			rd_data = {sleep_q, pin_flag_q, en_q, rsv_q, sel_q};
		end else if (ptr_q == REG_CBC) begin
			rd_data = bal_q;
		end
	end

	// ----------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_q <= 8'h00;
			zero_q <= 1'b0;
		end else begin
			tap_q <= en_q ? (8'h01 << sel_q) : 8'h00;
			zero_q <= 1'b0;
		end
	end

	assign sleep_request = sleep_q;
	assign monitor_enable = en_q;
	assign cell_select = sel_q;
	assign cell_tap_select = tap_q;
	assign balance_switch_enable = bal_q;
	assign bus.sda_s_oe = sda_oe_q;
	assign bus.sda_s_o = zero_q;
	assign bus.scl_s_oe = zero_q;
	assign bus.scl_s_o = zero_q;
endmodule // cmi_slave

// ---- hw/cmi_host.sv ----
/*
 Controller end: two-wire bus master ordered over APB.
 Assumes an APB master on pclk and pull-ups on the bus.
*/
`timescale 1ns/1ns
module cmi_host #(
	parameter int QTR = 25
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	cmi_bus_if.master bus
);
	import cmi_pkg::*;

	localparam int QW = $clog2(QTR + 1);

	logic [1:0] scl_s, sda_s;
	logic pready_q, pslverr_q, acc, busy_q, nack_q, zero_q;
	logic [31:0] prdata_q;
	logic cmd_rd_q, go;
	logic [7:0] cmd_reg_q, cmd_dat_q, tx_q, rx_q, rdat_q, ntx;
	logic [QW-1:0] qcnt_q;
	logic tick;
	cmi_ms_st_t st_q, nst;
	logic [1:0] ph_q;
	logic [2:0] step_q, nstep;
	logic [3:0] bit_q;
	logic rdb_q, nrd, scl_oe_q, sda_oe_q;

	// ----------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------
	assign acc = psel & penable & ~pready_q;
	assign go = acc & pwrite & (paddr == HOST_CMD_OFS) & ~busy_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc & (paddr != HOST_CMD_OFS) & (paddr != HOST_STAT_OFS);
			if (acc && !pwrite) begin
				if (paddr == HOST_CMD_OFS) begin
					prdata_q <= {15'h0, cmd_rd_q, cmd_dat_q, cmd_reg_q};
				end else if (paddr == HOST_STAT_OFS) begin
					prdata_q <= {16'h0, rdat_q, 6'h00, nack_q, busy_q};
				end else begin
					prdata_q <= 32'h0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_rd_q <= 1'b0;
			cmd_reg_q <= 8'h00;
			cmd_dat_q <= 8'h00;
		end else if (go) begin
			cmd_rd_q <= pwdata[CMD_RD_BIT];
			cmd_reg_q <= pwdata[CMD_REG_LSB +: 8];
			cmd_dat_q <= pwdata[CMD_DAT_LSB +: 8];
		end
	end

	// ----------------------------------------------------------
	// Pin synchronisers and quarter-bit divider
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			qcnt_q <= '0;
			zero_q <= 1'b0;
		end else begin
			scl_s <= {scl_s[0], bus.scl};
			sda_s <= {sda_s[0], bus.sda};
			zero_q <= 1'b0;
			qcnt_q <= (tick || st_q == MS_IDLE) ? '0 : qcnt_q + QW'(1);
		end
	end

	assign tick = (qcnt_q == QW'(QTR - 1));

	// ----------------------------------------------------------
	// Next transfer item
	// ----------------------------------------------------------
	assign nstep = step_q + 3'h1;

	always_comb begin
		nst = MS_BIT;
		ntx = 8'h00;
		nrd = 1'b0;
		case (nstep)
			STEP_AW: ntx = {SLV_ADDR, DIR_WR};
			STEP_REG: ntx = cmd_reg_q;
			STEP_DAT: begin
				if (cmd_rd_q) begin
					nst = MS_START;
				end else begin
					ntx = cmd_dat_q;
				end
			end
			STEP_AR: begin
				if (cmd_rd_q) begin
					ntx = {SLV_ADDR, DIR_RD};
				end else begin
					nst = MS_STOP;
				end
			end
			STEP_RD: nrd = 1'b1;
			default: nst = MS_STOP;
		endcase
	end

	// ----------------------------------------------------------
	// Bus sequencer
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= MS_IDLE;
			ph_q <= 2'h0;
			step_q <= 3'h0;
			bit_q <= 4'h0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			rdat_q <= 8'h00;
			rdb_q <= 1'b0;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (go) begin
			busy_q <= 1'b1;
			nack_q <= 1'b0;
		end else begin
			unique case (st_q)
				MS_IDLE: begin
					if (busy_q && scl_s[1] && sda_s[1]) begin
						st_q <= MS_START;
						ph_q <= 2'h0;
						step_q <= 3'h0;
					end
				end
				MS_START: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							2'h3: begin
								scl_oe_q <= 1'b1;
								step_q <= nstep;
								st_q <= nst;
								tx_q <= ntx;
								rdb_q <= nrd;
								bit_q <= 4'h0;
							end
						endcase
					end
				end
				MS_BIT: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							// Read data and its final not-acknowledge leave the line released
							2'h0: sda_oe_q <= ~rdb_q & (bit_q != BYTE_BITS) & ~tx_q[7];
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								if (bit_q == BYTE_BITS) begin
									nack_q <= nack_q | (~rdb_q & sda_s[1]);
								end else if (rdb_q) begin
									rx_q <= {rx_q[6:0], sda_s[1]};
								end
							end
							2'h3: begin
								scl_oe_q <= 1'b1;
								if (bit_q == BYTE_BITS) begin
									if (rdb_q) begin
										rdat_q <= rx_q;
									end
									step_q <= nstep;
									st_q <= nack_q ? MS_STOP : nst;
									tx_q <= ntx;
									rdb_q <= nrd;
									bit_q <= 4'h0;
								end else begin
									bit_q <= bit_q + 4'h1;
									tx_q <= {tx_q[6:0], 1'b0};
								end
							end
						endcase
					end
				end
				MS_STOP: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							2'h3: begin
								st_q <= MS_IDLE;
								busy_q <= 1'b0;
							end
						endcase
					end
				end
				default: st_q <= MS_IDLE;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign bus.scl_m_oe = scl_oe_q;
	assign bus.sda_m_oe = sda_oe_q;
	assign bus.scl_m_o = zero_q;
	assign bus.sda_m_o = zero_q;
endmodule // cmi_host

// ---- bench/cmi_bus_chk.sv ----
/*
 Wire checker for the two-wire link between controller and monitor port.
 Assumes the carrier signals on pclk, presetn asynchronous active low.
*/
`timescale 1ns/1ns
module cmi_bus_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_m_o,
	input wire logic scl_m_oe,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic scl_s_o,
	input wire logic scl_s_oe,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	import cmi_pkg::*;
	logic [3:0] cnt_q;
	logic [1:0] byt_q;
	logic [7:0] sh_q;
	logic rd_q;
	logic busy_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			byt_q <= 2'h0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
		end else if (scl && $past(scl) && $fell(sda)) begin
			cnt_q <= 4'h0;
			byt_q <= 2'h0;
		end else if ($rose(scl)) begin
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			if (cnt_q < 4'h8) sh_q <= {sh_q[6:0], sda};
			if (cnt_q == 4'h8 && byt_q != 2'h3) byt_q <= byt_q + 2'h1;
			if (cnt_q == 4'h7 && byt_q == 2'h0) rd_q <= sda;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) busy_q <= 1'b0;
		else if (scl && $past(scl) && $fell(sda)) busy_q <= 1'b1;
		else if (scl && $past(scl) && $rose(sda)) busy_q <= 1'b0;
	end
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence ninth;
		$rose(scl) && cnt_q == 4'h8;
	endsequence
	a_open_drain_only: assert property (!(scl_m_o | sda_m_o | scl_s_o | sda_s_o))
		else $error("bus output driven high");
	a_no_clock_stretch: assert property (!scl_s_oe)
		else $error("monitor pulled the clock line");
	a_slave_data_low: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("monitor moved data while clock high");
	a_data_stable_high: assert property ($rose(scl) |=> $stable(sda) [*8])
		else $error("data moved early in clock high");
	a_addr_byte_ok: assert property (ninth ##0 byt_q == 2'h0 |-> sh_q[7:1] == SLV_ADDR)
		else $error("address byte not sent msb first");
	a_addr_acked: assert property (ninth ##0 byt_q == 2'h0 |-> !sda && sda_s_oe)
		else $error("own address not acknowledged");
	a_write_acked: assert property (ninth ##0 (byt_q != 2'h0 && !rd_q) |-> sda_s_oe)
		else $error("received byte not acknowledged");
	a_read_ack_free: assert property (ninth ##0 (byt_q != 2'h0 && rd_q) |-> !sda_s_oe)
		else $error("monitor drove the master acknowledge slot");
	a_ack_held: assert property ($rose(scl) && sda_s_oe |=> sda_s_oe [*8])
		else $error("monitor released data during clock high");
	a_quiet_when_free: assert property (!busy_q |-> !sda_s_oe)
		else $error("monitor drove a free bus");
endmodule // cmi_bus_chk

// ---- bench/tb_cell_monitor_i2c_slave.sv ----
/*
 Testbench: controller and monitor joined on one bus, plus a second monitor
 driven bit by bit. Assumes the shared package and carrier interface.
*/
`timescale 1ns/1ns
module tb_cell_monitor_i2c_slave;
	import cmi_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, high_voltage_wake_pin = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, sleep_request, monitor_enable;
	logic [SEL_W-1:0] cell_select;
	logic [7:0] cell_tap_select, balance_switch_enable;
	logic s2_sleep, s2_en;
	logic [SEL_W-1:0] s2_sel;
	logic [7:0] s2_tap, s2_bal;
	int miscompares = 0, checked = 0;
	always #5 pclk = ~pclk;
	cmi_bus_if bus ();
	cmi_bus_if bus2 ();
	cmi_host #(.QTR(10)) i_cmi_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus.master));
	cmi_slave #(.BUS_TIMEOUT_PERIOD_SHORT_CYC(2000), .BUS_TIMEOUT_PERIOD_LONG_CYC(4000)) i_cmi_slave (.pclk(pclk),
		.presetn(presetn), .bus(bus.slave), .high_voltage_wake_pin(high_voltage_wake_pin),
		.bus_timeout_period_long_sel(1'b0), .sleep_request(sleep_request), .monitor_enable(monitor_enable),
		.cell_select(cell_select), .cell_tap_select(cell_tap_select),
		.balance_switch_enable(balance_switch_enable));
	cmi_slave #(.BUS_TIMEOUT_PERIOD_SHORT_CYC(2000), .BUS_TIMEOUT_PERIOD_LONG_CYC(4000)) i_cmi_slave_2 (.pclk(pclk),
		.presetn(presetn), .bus(bus2.slave), .high_voltage_wake_pin(1'b0),
		.bus_timeout_period_long_sel(1'b1), .sleep_request(s2_sleep), .monitor_enable(s2_en),
		.cell_select(s2_sel), .cell_tap_select(s2_tap), .balance_switch_enable(s2_bal));
	cmi_bus_chk i_cmi_bus_chk (.pclk(pclk), .presetn(presetn), .scl_m_o(bus.scl_m_o),
		.scl_m_oe(bus.scl_m_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
		.scl_s_o(bus.scl_s_o), .scl_s_oe(bus.scl_s_oe), .sda_s_o(bus.sda_s_o),
		.sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			miscompares++;
			complete_run();
		end
	endtask
	task automatic xfer(input logic rd, input logic [7:0] ra, input logic [7:0] d,
		output logic [31:0] st);
		int k;
		logic [31:0] r;
		logic e;
		apb(1'b1, HOST_CMD_OFS, {15'h0, rd, d, ra}, r, e);
		k = 0;
		do begin
			apb(1'b0, HOST_STAT_OFS, 32'h0, st, e);
			k++;
		end while (st[0] !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			miscompares++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		logic [31:0] st;
		xfer(1'b0, ra, d, st);
		check(st[1], 1'b0);
	endtask
	task automatic rdchk(input logic [7:0] ra, input logic [7:0] want);
		logic [31:0] st;
		xfer(1'b1, ra, 8'h00, st);
		check(st[15:8], want);
	endtask
	task automatic b2(input logic b, output logic s);
		bus2.sda_m_oe <= ~b;
		tick(8);
		bus2.scl_m_oe <= 1'b0;
		tick(8);
		s = bus2.sda;
		tick(8);
		bus2.scl_m_oe <= 1'b1;
		tick(8);
	endtask
	task automatic b2_addr(input logic [7:0] a, output logic ack);
		logic s;
		bus2.sda_m_oe <= 1'b1;
		tick(8);
		bus2.scl_m_oe <= 1'b1;
		tick(8);
		for (int i = 7; i >= 0; i--) b2(a[i], s);
		b2(1'b1, s);
		ack = ~s;
	endtask
	task automatic b2_stop();
		bus2.sda_m_oe <= 1'b1;
		tick(8);
		bus2.scl_m_oe <= 1'b0;
		tick(8);
		bus2.sda_m_oe <= 1'b0;
		tick(8);
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		logic ack;
		bus2.scl_m_oe = 1'b0;
		bus2.sda_m_oe = 1'b0;
		tick(8);
		presetn <= 1'b1;
		tick(4);
		rdchk(REG_SMC, SMC_RST);
		rdchk(REG_CBC, CBC_RST);
		wr(REG_CBC, 8'h55);
		check(balance_switch_enable, 8'h55);
		rdchk(REG_CBC, 8'h55);
		for (int k = 0; k < 8; k++) begin
			wr(REG_SMC, 8'h20 | k[7:0]);
			check({monitor_enable, cell_select, cell_tap_select}, {1'b1, k[2:0], 8'h01 << k});
		end
		wr(REG_SMC, 8'h1f);
		check({monitor_enable, cell_tap_select}, 9'h000);
		rdchk(REG_SMC, 8'h1f);
		wr(8'h02, 8'hff);
		rdchk(8'h02, 8'h00);
		rdchk(REG_CBC, 8'h55);
		wr(REG_SMC, 8'h80);
		check(sleep_request, 1'b1);
		high_voltage_wake_pin <= 1'b1;
		tick(900);
		high_voltage_wake_pin <= 1'b0;
		tick(5);
		check(sleep_request, 1'b1);
		high_voltage_wake_pin <= 1'b1;
		tick(1100);
		check(sleep_request, 1'b0);
		rdchk(REG_SMC, 8'h40);
		wr(REG_SMC, 8'h80);
		check(sleep_request, 1'b0);
		high_voltage_wake_pin <= 1'b0;
		tick(5);
		rdchk(REG_SMC, 8'h00);
		wr(REG_SMC, 8'h40);
		rdchk(REG_SMC, 8'h00);
		wr(REG_SMC, 8'h80);
		check(sleep_request, 1'b0);
		wr(REG_SMC, 8'h00);
		wr(REG_SMC, 8'h80);
		check(sleep_request, 1'b1);
		apb(1'b0, 12'h008, 32'h0, r, e);
		check(e, 1'b1);
		check(r, 32'h0);
		b2_addr(8'ha8, ack);
		check(ack, 1'b0);
		b2_stop();
		b2_addr(8'hb9, ack);
		check(ack, 1'b1);
		tick(3000);
		check(bus2.sda_s_oe, 1'b1);
		tick(1100);
		check(bus2.sda_s_oe, 1'b0);
		check({s2_sleep, s2_en, s2_sel, s2_tap, s2_bal}, 21'h0);
		b2_stop();
		complete_run();
	end
endmodule // tb_cell_monitor_i2c_slave
